//--- core/dic_top.sv
// How it works
// - polarity per channel, default normally open
// - no: above activation threshold gives active
// - nc: above activation threshold gives inactive
// - no: below release threshold gives inactive
// - nc: below release threshold gives active
// - rising state waits activation delay in ms
// - falling state waits drop-off delay in ms
// - ac mode adds thirty ms fall delay
// - ac mode: release equals activation over ten
// - 32-bit tally counts every reported rise
// - clear strobe zeroes that channel's tally, or sets it to one if a rise lands in the same cycle
// - measured voltage reported in millivolts
// - every setting held separately per channel
// - channels sampled once per 5 ms scan
// - eight independent channels
`timescale 1ns/1ns
module dic_top #(
  parameter int MS_CYCLES_P = dic_pkg::MS_CYCLES
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // measured channel voltages in mV
  input wire dic_pkg::dic_mv_t [dic_pkg::NCH-1:0] i_volt_mv,
  // per-channel settings
  input wire logic [dic_pkg::NCH-1:0] i_nc,
  input wire logic [dic_pkg::NCH-1:0] i_ac,
  input wire dic_pkg::dic_thr_t [dic_pkg::NCH-1:0] i_act_thr,
  input wire dic_pkg::dic_thr_t [dic_pkg::NCH-1:0] i_rel_thr,
  input wire dic_pkg::dic_dly_t [dic_pkg::NCH-1:0] i_rise_dly_ms,
  input wire dic_pkg::dic_dly_t [dic_pkg::NCH-1:0] i_fall_qualify_delay_ms,
  // per-channel commands
  input wire logic [dic_pkg::NCH-1:0] i_tally_clear,
  // conditioned state and status
  output logic [dic_pkg::NCH-1:0] o_state,
  output logic [dic_pkg::NCH-1:0] o_rise,
  output dic_pkg::dic_tally_t [dic_pkg::NCH-1:0] o_rise_transition_tally,
  output dic_pkg::dic_mv_t [dic_pkg::NCH-1:0] o_volt_mv,
  output logic o_scan_tick
);
  import dic_pkg::*;

  localparam int MS_W = $clog2(MS_CYCLES_P + 1);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES_P - 1);

  logic [MS_W-1:0] ms_cnt_reg;
  logic [2:0] scan_cnt_reg;
  logic ms_tick;
  logic scan_tick;
  logic [NCH-1:0] energized_reg;
  logic [NCH-1:0] raw;
  logic [NCH-1:0] rise;
  dic_tally_t [NCH-1:0] tally_reg;
  dic_mv_t [NCH-1:0] volt_reg;

  // millisecond base
  assign ms_tick = i_ce && (ms_cnt_reg == MS_LAST);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ms_cnt_reg <= '0;
    end else if (i_ce) begin
      if (ms_cnt_reg == MS_LAST) ms_cnt_reg <= '0;
      else ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  // scan every fifth ms tick
  assign scan_tick = ms_tick && (scan_cnt_reg == SCAN_LAST);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scan_cnt_reg <= '0;
    end else if (ms_tick) begin
      if (scan_cnt_reg == SCAN_LAST) scan_cnt_reg <= '0;
      else scan_cnt_reg <= scan_cnt_reg + 3'h1;
    end
  end

  assign o_scan_tick = scan_tick;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      dic_mv_t act_mv;
      dic_mv_t rel_prog_mv;
      dic_mv_t rel_ac_mv;
      dic_mv_t rel_mv;

      assign act_mv = MV_W'(i_act_thr[ch]) * MV_PER_THR_STEP;
      assign rel_prog_mv = MV_W'(i_rel_thr[ch]) * MV_PER_THR_STEP;
      assign rel_ac_mv = MV_W'(i_act_thr[ch]) * MV_PER_AC_REL_STEP;
      assign rel_mv = i_ac[ch] ? rel_ac_mv : rel_prog_mv;

      // energized level with hysteresis; activation wins on misordered thresholds
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          energized_reg[ch] <= 1'b0;
        end else if (scan_tick) begin
          if (i_volt_mv[ch] > act_mv) energized_reg[ch] <= 1'b1;
          else if (i_volt_mv[ch] < rel_mv) energized_reg[ch] <= 1'b0;
        end
      end

      assign raw[ch] = energized_reg[ch] ^ i_nc[ch];

      dic_qualify u_qualify (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_ms_tick(ms_tick),
        .i_scan_tick(scan_tick),
        .i_raw(raw[ch]),
        .i_ac(i_ac[ch]),
        .i_rise_dly(i_rise_dly_ms[ch]),
        .i_fall_dly(i_fall_qualify_delay_ms[ch]),
        .o_state(o_state[ch]),
        .o_rise(rise[ch])
      );

      // a rise in the same cycle as a clear is still counted
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          tally_reg[ch] <= TALLY_RST;
        end else if (i_ce) begin
          if (i_tally_clear[ch]) tally_reg[ch] <= rise[ch] ? 32'h0000_0001 : TALLY_RST;
          else if (rise[ch]) tally_reg[ch] <= tally_reg[ch] + 32'h0000_0001;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          volt_reg[ch] <= '0;
        end else if (scan_tick) begin
          volt_reg[ch] <= i_volt_mv[ch];
        end
      end

      a_act_energize: assert property (@(posedge i_clk) disable iff (i_reset)
        scan_tick && i_volt_mv[ch] > act_mv |=> energized_reg[ch] == 1'b1)
        else $error("voltage above activation did not energize");

      a_nc_invert: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_state[ch]) |-> $past(energized_reg[ch]) != $past(i_nc[ch]))
        else $error("reported rise disagrees with polarity");

      a_nc_active_low: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(o_state[ch]) && $past(i_nc[ch]) |-> $past(energized_reg[ch]))
        else $error("nc fall without energized input");

      a_rel_release: assert property (@(posedge i_clk) disable iff (i_reset)
        scan_tick && !(i_volt_mv[ch] > act_mv) && i_volt_mv[ch] < rel_mv
        |=> energized_reg[ch] == 1'b0)
        else $error("voltage below release did not de-energize");

      a_nc_release: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_state[ch]) && $past(i_nc[ch]) |-> !$past(energized_reg[ch]))
        else $error("nc rise with energized input");

      a_band_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        scan_tick && i_volt_mv[ch] <= act_mv && i_volt_mv[ch] >= rel_mv
        |=> $stable(energized_reg[ch]))
        else $error("level changed inside hysteresis band");

      a_ac_release: assert property (@(posedge i_clk) disable iff (i_reset)
        scan_tick && i_ac[ch] && i_volt_mv[ch] <= act_mv
        && i_volt_mv[ch] >= rel_ac_mv && i_volt_mv[ch] < rel_prog_mv
        |=> $stable(energized_reg[ch]))
        else $error("ac mode used programmed release");

      a_scan_only: assert property (@(posedge i_clk) disable iff (i_reset)
        !scan_tick |=> $stable(energized_reg[ch]) && $stable(volt_reg[ch]))
        else $error("channel sampled outside scan");

      a_tally_inc: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && rise[ch] && !i_tally_clear[ch]
        |=> tally_reg[ch] == $past(tally_reg[ch]) + 32'h0000_0001)
        else $error("tally missed a rise");

      a_tally_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_tally_clear[ch] && !rise[ch] |=> tally_reg[ch] == TALLY_RST)
        else $error("tally not cleared");

      a_tally_rise_src: assert property (@(posedge i_clk) disable iff (i_reset)
        rise[ch] |-> o_state[ch] && $past(!o_state[ch]))
        else $error("rise pulse without state edge");

      a_volt_report: assert property (@(posedge i_clk) disable iff (i_reset)
        scan_tick |=> volt_reg[ch] == $past(i_volt_mv[ch]))
        else $error("voltage report not updated");

      c_rise: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_state[ch]));
      c_fall: cover property (@(posedge i_clk) disable iff (i_reset) $fell(o_state[ch]));
      c_clear: cover property (@(posedge i_clk) disable iff (i_reset)
        i_ce && i_tally_clear[ch] && tally_reg[ch] != TALLY_RST);
    end
  endgenerate

  assign o_rise = rise;
  assign o_rise_transition_tally = tally_reg;
  assign o_volt_mv = volt_reg;

  a_scan_period: assert property (@(posedge i_clk) disable iff (i_reset)
    scan_tick |-> ms_tick && scan_cnt_reg == SCAN_LAST)
    else $error("scan tick off the 5 ms grid");

  a_freeze: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_ce |=> $stable(ms_cnt_reg) && $stable(scan_cnt_reg) && $stable(tally_reg))
    else $error("state moved with clock enable low");

  c_scan: cover property (@(posedge i_clk) disable iff (i_reset) scan_tick);
endmodule // dic_top

//--- core/dic_pkg.sv
package dic_pkg;

  // channel count and data widths
  localparam int NCH = 8;
  localparam int MV_W = 19;
  localparam int THR_W = 11;
  localparam int DLY_W = 21;
  localparam int ELAP_W = 22;
  localparam int TALLY_W = 32;

  typedef logic [MV_W-1:0] dic_mv_t;
  typedef logic [THR_W-1:0] dic_thr_t;
  typedef logic [DLY_W-1:0] dic_dly_t;
  typedef logic [ELAP_W-1:0] dic_elap_t;
  typedef logic [TALLY_W-1:0] dic_tally_t;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SCAN_LAST = 3'h4;
  localparam dic_elap_t AC_EXTRA_MS = 22'h00_001E;

  // threshold scaling: one step is 0.1 V, i.e. 100 mV; ac release is act/10
  localparam dic_mv_t MV_PER_THR_STEP = 19'h0_0064;
  localparam dic_mv_t MV_PER_AC_REL_STEP = 19'h0_000A;

  // values that firmware loads after reset, plus the tally's reset and clear value
  localparam dic_thr_t ACT_THR_DEF = 11'h370;
  localparam dic_thr_t REL_THR_DEF = 11'h258;
  localparam dic_dly_t RISE_DLY_DEF = 21'h00_0000;
  localparam dic_dly_t FALL_DLY_DEF = 21'h00_0000;
  localparam logic NC_DEF = 1'b0;
  localparam logic AC_DEF = 1'b0;
  localparam dic_tally_t TALLY_RST = 32'h0000_0000;

  // qualifier states, gray along low-rise-high-fall; bit 1 is the reported state
  typedef enum logic [1:0] {
    QS_LOW = 2'h0,
    QS_RISE = 2'h1,
    QS_HIGH = 2'h3,
    QS_FALL = 2'h2
  } dic_qual_e;

endpackage

//--- core/dic_qualify.sv
`timescale 1ns/1ns
module dic_qualify (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // timing strobes
  input wire logic i_ms_tick,
  input wire logic i_scan_tick,
  // raw state and settings
  input wire logic i_raw,
  input wire logic i_ac,
  input wire dic_pkg::dic_dly_t i_rise_dly,
  input wire dic_pkg::dic_dly_t i_fall_dly,
  // qualified state
  output logic o_state,
  output logic o_rise
);
  import dic_pkg::*;

  dic_qual_e state_reg;
  dic_qual_e state_next;
  dic_elap_t elapsed_reg;
  dic_elap_t rise_lim;
  dic_elap_t fall_lim;
  logic rise_reg;

  assign rise_lim = ELAP_W'(i_rise_dly);
  assign fall_lim = ELAP_W'(i_fall_dly) + (i_ac ? AC_EXTRA_MS : '0);

  always_comb begin
    state_next = state_reg;
    if (i_scan_tick) begin
      unique case (state_reg)
        QS_LOW: if (i_raw) state_next = (rise_lim == '0) ? QS_HIGH : QS_RISE;
        QS_RISE: begin
          if (!i_raw) state_next = QS_LOW;
          else if (elapsed_reg >= rise_lim) state_next = QS_HIGH;
        end
        QS_HIGH: if (!i_raw) state_next = (fall_lim == '0) ? QS_LOW : QS_FALL;
        QS_FALL: begin
          if (i_raw) state_next = QS_HIGH;
          else if (elapsed_reg >= fall_lim) state_next = QS_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= QS_LOW;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // pending time in ms; only runs while a change waits to qualify
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      elapsed_reg <= '0;
    end else if (i_ce) begin
      if (state_reg == QS_LOW || state_reg == QS_HIGH) elapsed_reg <= '0;
      else if (i_ms_tick) elapsed_reg <= elapsed_reg + 22'h00_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rise_reg <= 1'b0;
    end else if (i_ce) begin
      rise_reg <= state_next[1] & ~state_reg[1];
    end
  end

  assign o_state = state_reg[1];
  assign o_rise = rise_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_rise_delay: assert property ($rose(state_reg[1]) |-> $past(elapsed_reg) >= $past(rise_lim))
    else $error("state rose before activation delay");
  a_fall_delay: assert property ($fell(state_reg[1]) |-> $past(elapsed_reg) >= $past(fall_lim))
    else $error("state fell before drop-off delay");
  a_ac_extra: assert property ($fell(state_reg[1]) && $past(i_ac) |-> $past(elapsed_reg) >= 30)
    else $error("ac fall without extra delay");
  a_pend_restart: assert property (i_ce && i_scan_tick && state_reg == QS_RISE && !i_raw
    |=> state_reg == QS_LOW)
    else $error("pending rise not abandoned");
  c_ac_fall: cover property (i_ac ##1 $fell(state_reg[1]));
endmodule // dic_qualify

//--- tb/dic_field.sv
`timescale 1ns/1ns
module dic_field (
  // requested contact voltages in mV
  input wire dic_pkg::dic_mv_t [dic_pkg::NCH-1:0] i_mv,
  // voltages seen at the input channels
  output dic_pkg::dic_mv_t [dic_pkg::NCH-1:0] o_volt_mv
);
  import dic_pkg::*;
  // the card's measuring span tops out at 275 V
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      o_volt_mv[c] = (i_mv[c] > 19'h4_3238) ? 19'h4_3238 : i_mv[c];
    end
  end
endmodule // dic_field

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  import dic_pkg::*;
  typedef struct {logic nc; logic ac; dic_mv_t mv; logic exp;} dic_row_s;
  logic i_clk, i_reset, i_ce, o_scan_tick, prev;
  logic [NCH-1:0] i_nc, i_ac, i_tally_clear, o_state, o_rise;
  dic_thr_t [NCH-1:0] i_act_thr, i_rel_thr;
  dic_dly_t [NCH-1:0] i_rise_dly_ms, i_fall_qualify_delay_ms;
  dic_mv_t [NCH-1:0] req_mv, i_volt_mv, o_volt_mv;
  dic_tally_t [NCH-1:0] o_rise_transition_tally;
  int err_total, checks_done, exp_tally, n;
  // channel 0 walks through polarity, hysteresis and ac release cases
  dic_row_s rows[9] = '{
    '{1'b0, 1'b0, 19'h1_5F90, 1'b1}, '{1'b0, 1'b0, 19'h1_1170, 1'b1},
    '{1'b0, 1'b0, 19'h0_C350, 1'b0}, '{1'b0, 1'b0, 19'h1_1170, 1'b0},
    '{1'b1, 1'b0, 19'h1_5F90, 1'b0}, '{1'b1, 1'b0, 19'h0_C350, 1'b1},
    '{1'b0, 1'b1, 19'h1_5F90, 1'b1}, '{1'b0, 1'b1, 19'h0_C350, 1'b1},
    '{1'b0, 1'b1, 19'h0_1F40, 1'b0}
  };

  dic_field field (.i_mv(req_mv), .o_volt_mv(i_volt_mv));

  dic_top #(.MS_CYCLES_P(4)) uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_volt_mv(i_volt_mv),
    .i_nc(i_nc), .i_ac(i_ac), .i_act_thr(i_act_thr), .i_rel_thr(i_rel_thr),
    .i_rise_dly_ms(i_rise_dly_ms), .i_fall_qualify_delay_ms(i_fall_qualify_delay_ms),
    .i_tally_clear(i_tally_clear), .o_state(o_state), .o_rise(o_rise),
    .o_rise_transition_tally(o_rise_transition_tally), .o_volt_mv(o_volt_mv),
    .o_scan_tick(o_scan_tick)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // waits for cnt scan ticks, then lets that last scan edge land
  task automatic scans(input int cnt);
    int k;
    k = 0;
    while (cnt > 0) begin
      @(negedge i_clk);
      k++;
      if (o_scan_tick === 1'b1) cnt--;
      if (k > 400) begin
        err_total++;
        report_and_stop();
      end
    end
    @(negedge i_clk);
  endtask

  initial begin
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_nc = '0;
    i_ac = '0;
    i_tally_clear = '0;
    req_mv = '0;
    i_act_thr = {NCH{ACT_THR_DEF}};
    i_rel_thr = {NCH{REL_THR_DEF}};
    i_rise_dly_ms = {NCH{RISE_DLY_DEF}};
    i_fall_qualify_delay_ms = {NCH{FALL_DLY_DEF}};
    err_total = 0;
    checks_done = 0;
    exp_tally = 0;
    prev = 1'b0;
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    chk(o_rise_transition_tally[0], 0);
    chk(o_volt_mv[0], 0);
    $display("test reset done");
    foreach (rows[r]) begin
      i_nc[0] = rows[r].nc;
      i_ac[0] = rows[r].ac;
      req_mv[0] = rows[r].mv;
      scans(10);
      chk(o_state[0], rows[r].exp);
      chk(o_volt_mv[0], rows[r].mv);
      if (rows[r].exp && !prev) exp_tally++;
      prev = rows[r].exp;
    end
    $display("test rows done");
    // the fifth row turns nc on while still de-energized, so it reads active for one scan
    chk(o_rise_transition_tally[0], exp_tally + 1);
    i_tally_clear[0] = 1'b1;
    @(negedge i_clk);
    i_tally_clear[0] = 1'b0;
    @(negedge i_clk);
    chk(o_rise_transition_tally[0], 0);
    $display("test tally done");
    i_ac[0] = 1'b0;
    i_rise_dly_ms[0] = 21'h00_000C;
    i_fall_qualify_delay_ms[0] = 21'h00_000C;
    req_mv[0] = 19'h1_5F90;
    scans(2);
    chk(o_state[0], 1'b0);
    scans(3);
    chk(o_state[0], 1'b1);
    chk(o_rise[0], 1'b1);
    req_mv[0] = 19'h0_0000;
    scans(2);
    chk(o_state[0], 1'b1);
    scans(3);
    chk(o_state[0], 1'b0);
    $display("test delays done");
    i_rise_dly_ms[0] = 21'h00_0000;
    i_fall_qualify_delay_ms[0] = 21'h00_0000;
    req_mv[0] = 19'h1_5F90;
    scans(3);
    i_ac[0] = 1'b1;
    req_mv[0] = 19'h0_0000;
    scans(6);
    chk(o_state[0], 1'b1);
    scans(3);
    chk(o_state[0], 1'b0);
    chk(o_rise_transition_tally[0], 2);
    $display("test ac done");
    i_ac[0] = 1'b0;
    i_nc[3] = 1'b1;
    req_mv[7] = 19'h1_5F90;
    scans(3);
    chk(o_state, 8'h88);
    $display("test channels done");
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_scan_tick !== 1'b1 && n < 100);
    // one negedge of the period was already spent inside scans
    chk(n, 5 * 4 - 1);
    $display("test scan period done");
    report_and_stop();
  end
endmodule // tb
